/* inc/mrcs_pkg.sv */
// Purpose: Shared constants and types of the multiply-accumulate result path.
// Assumes: One clock domain, 16-bit operands and 40-bit accumulators.
// Notes:   Section offsets double as addresses on the register port.
package mrcs_pkg;

  localparam int SEC_W    = 16;
  localparam int ACC_W    = 40;
  localparam int ADDR_W   = 3;
  localparam int LOW_LSB  = 0;
  localparam int MID_LSB  = 16;
  localparam int HIGH_LSB = 32;
  localparam int HIGH_W   = 8;
  localparam int OVF_LSB  = 31;

  localparam logic [ADDR_W-1:0] OFS_A_LOW  = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_A_MID  = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_A_HIGH = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_B_LOW  = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_B_MID  = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_B_HIGH = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h6;

  localparam int STAT_BIT_A = 6;
  localparam int STAT_BIT_B = 8;

  localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [ACC_W-1:0] SAT_POS   = 40'h00_7FFF_FFFF;
  localparam logic [ACC_W-1:0] SAT_NEG   = 40'hFF_8000_0000;
  localparam logic [ACC_W-1:0] RND_BIAS  = 40'h00_0000_8000;
  localparam logic             FLAG_RESET = 1'b0;

  typedef enum logic [2:0] {
    K_MUL, K_MAC_ADD, K_MAC_SUB, K_CLEAR, K_ROUND, K_SAT
  } mrcs_kind_t;

  typedef enum logic [1:0] {
    both_signed, signed_x_unsigned_y, unsigned_x_signed_y, both_unsigned
  } mrcs_fmt_t;

  typedef enum logic [3:0] {
    SRC_XIN0, SRC_XIN1, SRC_YIN0, SRC_YIN1, SRC_ALU, SRC_DREG,
    SRC_A_LOW, SRC_A_MID, SRC_A_HIGH, SRC_B_LOW, SRC_B_MID, SRC_B_HIGH,
    SRC_SQUARE
  } mrcs_src_t;

  typedef struct packed {
    logic       valid;
    logic       cond_true;
    mrcs_kind_t kind;
    logic       dest_b;
    logic       rnd;
    logic       frac;
    mrcs_fmt_t  fmt;
    logic       restricted;
    mrcs_src_t  x_src;
    mrcs_src_t  y_src;
  } mrcs_op_t;

  typedef struct packed {
    logic [SEC_W-1:0] x_input_reg0;
    logic [SEC_W-1:0] x_input_reg1;
    logic [SEC_W-1:0] y_input_reg0;
    logic [SEC_W-1:0] y_input_reg1;
    logic [SEC_W-1:0] alu_result_reg;
    logic [SEC_W-1:0] dreg_x;
    logic [SEC_W-1:0] dreg_y;
  } mrcs_opnd_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [SEC_W-1:0]  wdata;
  } mrcs_bus_t;

endpackage

/* src/mrcs_mult.sv */
// Purpose: 16x16 multiplier with per-operand signedness and fractional shift.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   The extended product keeps the true sign for the 40-bit adder.
`timescale 1ns/1ns
`default_nettype none
module mrcs_mult #(
  parameter int OPND_W = 16,
  parameter int ACC_WIDTH = 40
) (
  // Operands
  input  wire logic [OPND_W-1:0]    x,
  input  wire logic [OPND_W-1:0]    y,
  // Format
  input  wire logic                 x_signed,
  input  wire logic                 y_signed,
  input  wire logic                 frac,
  // Results
  output logic      [2*OPND_W-1:0]  prod,
  output logic      [ACC_WIDTH-1:0] prod_ext
);
  logic signed [OPND_W:0]     xs;
  logic signed [OPND_W:0]     ys;
  logic signed [2*OPND_W+1:0] full;
  logic signed [2*OPND_W+1:0] shifted;

  assign xs   = {x_signed & x[OPND_W-1], x};
  assign ys   = {y_signed & y[OPND_W-1], y};
  assign full = xs * ys;
  // Fractional products drop the redundant sign bit for every format.
  assign shifted  = frac ? (full <<< 1) : full;
  assign prod     = shifted[2*OPND_W-1:0];
  assign prod_ext = {{(ACC_WIDTH-2*OPND_W-2){shifted[2*OPND_W+1]}}, shifted};
endmodule
`default_nettype wire

/* src/mrcs_mac.sv */
// Purpose: Multiply-accumulate result path with clear, round and saturate.
// Assumes: Instruction decoder presents one operation per enabled cycle.
// Notes:   Flags follow the last operation other than saturate on their accumulator, never port loads.
`timescale 1ns/1ns
`default_nettype none
module mrcs_mac (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           clk_en,
  // Operation from the decoder
  input  wire mrcs_pkg::mrcs_op_t             op,
  input  wire mrcs_pkg::mrcs_opnd_t           opnd,
  // Register port
  input  wire mrcs_pkg::mrcs_bus_t            bus,
  output logic      [mrcs_pkg::SEC_W-1:0]     rdata,
  // Accumulators and status
  output logic      [mrcs_pkg::ACC_W-1:0]     mac_result_a,
  output logic      [mrcs_pkg::ACC_W-1:0]     mac_result_b,
  output logic      [mrcs_pkg::SEC_W-1:0]     arith_status_reg,
  output logic                                op_refused
);
  import mrcs_pkg::*;

  function automatic logic ovf(input logic [ACC_W-1:0] v);
    return !((&v[ACC_W-1:OVF_LSB]) || !(|v[ACC_W-1:OVF_LSB]));
  endfunction

  // The upper section reads as 16 bits with bits 15:8 copying bit 7.
  function automatic logic [SEC_W-1:0] hi16(input logic [ACC_W-1:0] v);
    return {{(SEC_W-HIGH_W){v[ACC_W-1]}}, v[HIGH_LSB +: HIGH_W]};
  endfunction

  function automatic logic [SEC_W-1:0] pick(input mrcs_src_t s,
                                            input mrcs_opnd_t o,
                                            input logic [ACC_W-1:0] a,
                                            input logic [ACC_W-1:0] b);
    logic [SEC_W-1:0] r;
    r = '0;
    unique case (s)
      SRC_XIN0:   r = o.x_input_reg0;
      SRC_XIN1:   r = o.x_input_reg1;
      SRC_YIN0:   r = o.y_input_reg0;
      SRC_YIN1:   r = o.y_input_reg1;
      SRC_ALU:    r = o.alu_result_reg;
      SRC_DREG:   r = o.dreg_x;
      SRC_A_LOW:  r = a[LOW_LSB +: SEC_W];
      SRC_A_MID:  r = a[MID_LSB +: SEC_W];
      SRC_A_HIGH: r = hi16(a);
      SRC_B_LOW:  r = b[LOW_LSB +: SEC_W];
      SRC_B_MID:  r = b[MID_LSB +: SEC_W];
      SRC_B_HIGH: r = hi16(b);
      default:    r = o.dreg_y;
    endcase
    return r;
  endfunction

  function automatic logic legal_x(input mrcs_src_t s);
    return s inside {SRC_XIN0, SRC_XIN1, SRC_ALU, SRC_A_LOW, SRC_A_MID,
                     SRC_A_HIGH, SRC_B_MID, SRC_B_HIGH};
  endfunction

  function automatic logic legal_y(input mrcs_src_t s);
    return s inside {SRC_YIN0, SRC_YIN1, SRC_B_MID, SRC_SQUARE};
  endfunction

  logic [ACC_W-1:0]       acc  [2];
  logic [ACC_W-1:0]       next_acc [2];
  logic                   flag [2];
  logic                   next_flag [2];
  logic                   next_refused;
  logic [SEC_W-1:0]       next_rdata;

  wire logic              op_bad;
  wire logic              op_fire;
  wire logic              mul_kind;
  wire logic [ACC_W-1:0]  acc_cur;
  wire logic [SEC_W-1:0]  x_opnd;
  wire logic [SEC_W-1:0]  y_opnd;
  wire logic              x_signed;
  wire logic              y_signed;
  wire logic [ACC_W-1:0]  prod_ext;
  wire logic [ACC_W-1:0]  sum;
  wire logic [ACC_W-1:0]  mul_val;
  wire logic [ACC_W-1:0]  rnd_val;
  wire logic [ACC_W-1:0]  sat_val;
  logic      [ACC_W-1:0]  op_val;
  logic                   op_flag;
  logic                   op_flag_upd;

  // In the restricted case a bad selection is refused rather than guessed.
  assign op_bad   = op.restricted &
                    (!legal_x(op.x_src) || !legal_y(op.y_src));
  assign op_fire  = clk_en & op.valid & op.cond_true & !op_bad;
  assign mul_kind = op.kind inside {K_MUL, K_MAC_ADD, K_MAC_SUB};

  // Operands and the old accumulator are the values held since the last edge.
  assign acc_cur  = op.dest_b ? acc[1] : acc[0];
  assign x_opnd   = pick(op.x_src, opnd, acc[0], acc[1]);
  assign y_opnd   = (op.y_src == SRC_SQUARE) ? x_opnd :
                    (op.y_src == SRC_DREG)   ? opnd.dreg_y :
                    pick(op.y_src, opnd, acc[0], acc[1]);
  assign x_signed = op.fmt inside {both_signed, signed_x_unsigned_y};
  assign y_signed = op.fmt inside {both_signed, unsigned_x_signed_y};

  mrcs_mult #(
    .OPND_W    (SEC_W),
    .ACC_WIDTH (ACC_W)
  ) u_mult (
    .x        (x_opnd),
    .y        (y_opnd),
    .x_signed (x_signed),
    .y_signed (y_signed),
    .frac     (op.frac),
    .prod     (),
    .prod_ext (prod_ext)
  );

  // In an accumulate, a zero product leaves the sum equal to the old value for a flag refresh.
  assign sum     = (op.kind == K_MAC_SUB) ? acc_cur - prod_ext :
                   (op.kind == K_MAC_ADD) ? acc_cur + prod_ext : prod_ext;
  assign mul_val = (op.rnd && op.frac) ? sum + RND_BIAS : sum;
  // The round op adds the same RND_BIAS as the round option, in an adder of its own.
  assign rnd_val = op.frac ? acc_cur + RND_BIAS : acc_cur;
  // Saturate looks at the bits themselves, never at the stored flag.
  assign sat_val = !ovf(acc_cur) ? acc_cur :
                   acc_cur[ACC_W-1] ? SAT_NEG : SAT_POS;

  always_comb begin
    op_val      = acc_cur;
    op_flag     = FLAG_RESET;
    op_flag_upd = 1'b0;
    unique case (op.kind)
      K_MUL, K_MAC_ADD, K_MAC_SUB: begin
        op_val      = mul_val;
        op_flag     = ovf(mul_val);
        op_flag_upd = 1'b1;
      end
      K_CLEAR: begin
        op_val      = ACC_RESET;
        op_flag     = FLAG_RESET;
        op_flag_upd = 1'b1;
      end
      K_ROUND: begin
        op_val      = rnd_val;
        op_flag     = ovf(rnd_val);
        op_flag_upd = 1'b1;
      end
      K_SAT: begin
        op_val      = sat_val;
        op_flag_upd = 1'b0;
      end
      default: op_flag_upd = 1'b0;
    endcase
  end

  // A port write and an operation on the same accumulator: the operation wins.
  for (genvar i = 0; i < 2; i++) begin : g_acc
    wire logic hit;
    wire logic [ADDR_W-1:0] base;
    assign hit  = op_fire && (op.dest_b == (i == 1));
    assign base = (i == 1) ? OFS_B_LOW : OFS_A_LOW;

    always_comb begin
      next_acc[i]  = acc[i];
      next_flag[i] = flag[i];
      // Section loads keep the flag; a mid load sign-extends upward.
      if (clk_en && bus.wr) begin
        if (bus.addr == base) begin
          next_acc[i][LOW_LSB +: SEC_W] = bus.wdata;
        end else if (bus.addr == base + 3'h1) begin
          next_acc[i][ACC_W-1:MID_LSB] = {{HIGH_W{bus.wdata[SEC_W-1]}}, bus.wdata};
        end else if (bus.addr == base + 3'h2) begin
          next_acc[i][HIGH_LSB +: HIGH_W] = bus.wdata[HIGH_W-1:0];
        end
      end
      if (hit) begin
        next_acc[i] = op_val;
        if (op_flag_upd) begin
          next_flag[i] = op_flag;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        acc[i]  <= ACC_RESET;
        flag[i] <= FLAG_RESET;
      end else begin
        acc[i]  <= next_acc[i];
        flag[i] <= next_flag[i];
      end
    end
  end

  // Reads see the value before any update in the same cycle.
  always_comb begin
    next_rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_A_LOW:  next_rdata = acc[0][LOW_LSB +: SEC_W];
        OFS_A_MID:  next_rdata = acc[0][MID_LSB +: SEC_W];
        OFS_A_HIGH: next_rdata = hi16(acc[0]);
        OFS_B_LOW:  next_rdata = acc[1][LOW_LSB +: SEC_W];
        OFS_B_MID:  next_rdata = acc[1][MID_LSB +: SEC_W];
        OFS_B_HIGH: next_rdata = hi16(acc[1]);
        OFS_STATUS: next_rdata = arith_status_reg;
        default:    next_rdata = '0;
      endcase
    end
  end

  assign next_refused = op.valid & op.cond_true & op_bad;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata      <= '0;
      op_refused <= 1'b0;
    end else if (clk_en) begin
      rdata      <= next_rdata;
      op_refused <= next_refused;
    end
  end

  assign mac_result_a = acc[0];
  assign mac_result_b = acc[1];

  always_comb begin
    arith_status_reg             = '0;
    arith_status_reg[STAT_BIT_A] = flag[0];
    arith_status_reg[STAT_BIT_B] = flag[1];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  clear_zeroes_a: assert property (
    op_fire && op.kind == K_CLEAR
    |=> acc[$past(op.dest_b)] == ACC_RESET && !flag[$past(op.dest_b)])
    else $error("clear did not zero accumulator and flag");

  flag_tracks_a: assert property (
    op_fire && mul_kind |=> flag[$past(op.dest_b)] == ovf(acc[$past(op.dest_b)]))
    else $error("overflow flag disagrees with accumulator");

  other_flag_a: assert property (
    op_fire && op.kind == K_ROUND
    |=> ($past(op.dest_b) ? $stable(flag[0]) : $stable(flag[1])))
    else $error("round changed the other flag");

  load_keeps_a: assert property (
    clk_en && bus.wr && !op_fire |=> $stable(arith_status_reg))
    else $error("section load changed status");

  sat_pos_a: assert property (
    op_fire && op.kind == K_SAT && ovf(acc_cur) && !acc_cur[ACC_W-1]
    |=> acc[$past(op.dest_b)] == SAT_POS && $stable(arith_status_reg))
    else $error("positive saturation wrong");

  sat_neg_a: assert property (
    op_fire && op.kind == K_SAT && ovf(acc_cur) && acc_cur[ACC_W-1]
    |=> acc[$past(op.dest_b)] == SAT_NEG)
    else $error("negative saturation wrong");

  round_int_a: assert property (
    op_fire && op.kind == K_ROUND && !op.frac && !(bus.wr && clk_en)
    |=> $stable(mac_result_a) && $stable(mac_result_b))
    else $error("integer round changed contents");

  refuse_bad_a: assert property (
    clk_en && op.valid && op.cond_true && op_bad && !bus.wr
    |=> op_refused && $stable(mac_result_a) && $stable(mac_result_b))
    else $error("restricted operand not refused");

  read_old_a: assert property (
    clk_en && bus.rd && bus.addr == OFS_A_MID
    |=> rdata == $past(acc[0][MID_LSB +: SEC_W]))
    else $error("read did not return start-of-cycle value");

  mul_int_a: assert property (
    op_fire && op.kind == K_MUL && !op.frac && op.fmt == both_signed
    |=> $signed(acc[$past(op.dest_b)]) == $signed($past(x_opnd)) * $signed($past(y_opnd)))
    else $error("integer product wrong");

  mul_frac_a: assert property (
    op_fire && op.kind == K_MUL && op.frac && !op.rnd && op.fmt == both_signed
    |=> $signed(acc[$past(op.dest_b)]) == 2 * $signed($past(x_opnd)) * $signed($past(y_opnd)))
    else $error("fractional product not shifted");

  mul_other_a: assert property (
    op_fire && mul_kind
    |=> ($past(op.dest_b) ? $stable(flag[0]) : $stable(flag[1])))
    else $error("multiply changed the other flag");

  sat_flags_a: assert property (
    op_fire && op.kind == K_SAT |=> $stable(arith_status_reg))
    else $error("saturate changed a flag");

  sat_idle_a: assert property (
    op_fire && op.kind == K_SAT && !ovf(acc_cur)
    |=> acc[$past(op.dest_b)] == $past(acc_cur))
    else $error("saturate changed a value without overflow");

  round_frac_a: assert property (
    op_fire && op.kind == K_ROUND && op.frac
    |=> acc[$past(op.dest_b)] == $past(acc_cur) + RND_BIAS)
    else $error("fractional round wrong");

  first_flag_a: assert property (
    op_fire && mul_kind && !op.dest_b
    |=> arith_status_reg[STAT_BIT_A] == ovf(mac_result_a))
    else $error("status bit of accumulator a wrong");

  second_flag_a: assert property (
    op_fire && mul_kind && op.dest_b
    |=> arith_status_reg[STAT_BIT_B] == ovf(mac_result_b))
    else $error("status bit of accumulator b wrong");

  mid_load_a: assert property (
    clk_en && bus.wr && bus.addr == OFS_A_MID && !(op_fire && !op.dest_b)
    |=> mac_result_a[ACC_W-1:MID_LSB] ==
        {{HIGH_W{$past(bus.wdata[SEC_W-1])}}, $past(bus.wdata)})
    else $error("middle load did not sign-extend");

  refuse_legal_a: assert property (
    clk_en && !(op.valid && op.cond_true && op_bad) |=> !op_refused)
    else $error("legal operation refused");
endmodule
`default_nettype wire

/* bench/mrcs_rf_model.sv */
// Purpose: Register file model that feeds operand registers to the datapath.
// Assumes: Reloads land at the clock edge, like a memory move into the register file.
// Notes:   The datapath sees the old value in the cycle that the reload is issued.
`timescale 1ns/1ns
`default_nettype none
module mrcs_rf_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Reload request
  input  wire logic                 load,
  input  wire mrcs_pkg::mrcs_opnd_t load_val,
  // Operands to the datapath
  output var  mrcs_pkg::mrcs_opnd_t opnd
);
  import mrcs_pkg::*;

  // Reloading while the datapath reads the same register is the normal case.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opnd <= '0;
    end else if (load) begin
      opnd <= load_val;
    end
  end
endmodule
`default_nettype wire

/* bench/mac_result_clear_round_saturate_tb.sv */
// Purpose: Self-checking bench comparing the result path with a behavioural model.
// Assumes: Outputs are read at each edge before that edge's updates land.
// Notes:   Random operations, register port traffic and enable gaps run together.
`timescale 1ns/1ns
`default_nettype none
module mac_result_clear_round_saturate_tb;
  import mrcs_pkg::*;

  logic             clk      = 1'h0;
  logic             rst_b    = 1'h0;
  logic             clk_en   = 1'h0;
  logic             load     = 1'h0;
  mrcs_op_t         op       = '0;
  mrcs_bus_t        bus      = '0;
  mrcs_opnd_t       load_val = '0;
  mrcs_opnd_t       opnd;
  logic [SEC_W-1:0] rdata, status, e_rd;
  logic [ACC_W-1:0] acc_a, acc_b, ea, eb;
  logic             refused, fa, fb, e_ref;
  int               errors   = 0;
  int               n_checks = 0;

  always #2 clk = ~clk;

  mrcs_rf_model i_rf (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (load),
    .load_val (load_val),
    .opnd     (opnd)
  );

  mrcs_mac i_dut (
    .clk              (clk),
    .rst_b            (rst_b),
    .clk_en           (clk_en),
    .op               (op),
    .opnd             (opnd),
    .bus              (bus),
    .rdata            (rdata),
    .mac_result_a     (acc_a),
    .mac_result_b     (acc_b),
    .arith_status_reg (status),
    .op_refused       (refused)
  );

  task automatic cmp(input string what, input logic [ACC_W-1:0] exp, input logic [ACC_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_word(input string what, input logic [SEC_W-1:0] exp,
                          input logic [SEC_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic ovf(input logic [ACC_W-1:0] v);
    return !(&v[39:31] || ~|v[39:31]);
  endfunction

  function automatic logic [SEC_W-1:0] sect(input logic [ADDR_W-1:0] a);
    logic [ACC_W-1:0] v;
    v = (a < 3'h3) ? ea : eb;
    case (a)
      3'h0, 3'h3: return v[15:0];
      3'h1, 3'h4: return v[31:16];
      3'h2, 3'h5: return {{8{v[39]}}, v[39:32]};
      3'h6:       return {7'h00, fb, 1'h0, fa, 6'h00};
      default:    return 16'h0000;
    endcase
  endfunction

  function automatic logic [SEC_W-1:0] src(input mrcs_src_t s, input logic y, input mrcs_opnd_t o);
    case (s)
      SRC_XIN0: return o.x_input_reg0;
      SRC_XIN1: return o.x_input_reg1;
      SRC_YIN0: return o.y_input_reg0;
      SRC_YIN1: return o.y_input_reg1;
      SRC_ALU:  return o.alu_result_reg;
      SRC_DREG: return y ? o.dreg_y : o.dreg_x;
      default:  return (s >= SRC_A_LOW && s <= SRC_B_HIGH) ? sect(3'(s - SRC_A_LOW)) : 16'h0000;
    endcase
  endfunction

  // One cycle: drive, compare what the previous cycles left, then advance the model.
  task automatic step(input mrcs_op_t v, input mrcs_bus_t b, input logic en);
    logic [ACC_W-1:0] t, p, r, w;
    logic [16:0]      xe, ye;
    logic [SEC_W-1:0] x, y;
    logic             fire, bad;
    longint           pl;
    op <= v;
    bus <= b;
    clk_en <= en;
    @(posedge clk);
    cmp("acc a", ea, acc_a);
    cmp("acc b", eb, acc_b);
    cmp_word("status", {7'h00, fb, 1'h0, fa, 6'h00}, status);
    cmp_word("rdata", e_rd, rdata);
    cmp_bit("refused", e_ref, refused);
    if (en) begin
      bad = v.restricted && (!(v.x_src inside {SRC_XIN0, SRC_XIN1, SRC_ALU, SRC_A_LOW, SRC_A_MID,
            SRC_A_HIGH, SRC_B_MID, SRC_B_HIGH}) ||
            !(v.y_src inside {SRC_YIN0, SRC_YIN1, SRC_B_MID, SRC_SQUARE}));
      fire = v.valid && v.cond_true && !bad;
      e_ref = v.valid && v.cond_true && bad;
      x = src(v.x_src, 1'h0, opnd);
      y = (v.y_src == SRC_SQUARE) ? x : src(v.y_src, 1'h1, opnd);
      xe = {x[15] & (v.fmt inside {both_signed, signed_x_unsigned_y}), x};
      ye = {y[15] & (v.fmt inside {both_signed, unsigned_x_signed_y}), y};
      pl = longint'($signed(xe)) * longint'($signed(ye));
      pl = v.frac ? pl * 2 : pl;
      p = pl[39:0];
      r = (v.rnd && v.frac) ? 40'h00_0000_8000 : 40'h00_0000_0000;
      t = v.dest_b ? eb : ea;
      case (v.kind)
        K_MUL:     t = p + r;
        K_MAC_ADD: t = t + p + r;
        K_MAC_SUB: t = t - p + r;
        K_CLEAR:   t = 40'h00_0000_0000;
        K_ROUND:   t = v.frac ? t + 40'h00_0000_8000 : t;
        default:   t = !ovf(t) ? t : (t[39] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF);
      endcase
      e_rd = b.rd ? sect(b.addr) : 16'h0000;
      if (b.wr && b.addr < 3'h6 && !(fire && v.dest_b == (b.addr > 3'h2))) begin
        w = (b.addr > 3'h2) ? eb : ea;
        case (b.addr % 3'h3)
          3'h0:    w[15:0] = b.wdata;
          3'h1:    w[39:16] = {{8{b.wdata[15]}}, b.wdata};
          default: w[39:32] = b.wdata[7:0];
        endcase
        if (b.addr > 3'h2) eb = w;
        else ea = w;
      end
      if (fire && v.dest_b) eb = t;
      if (fire && !v.dest_b) ea = t;
      if (fire && v.kind != K_SAT && v.dest_b) fb = ovf(t);
      if (fire && v.kind != K_SAT && !v.dest_b) fa = ovf(t);
    end
  endtask

  initial begin : main
    mrcs_op_t  v;
    mrcs_bus_t b;
    void'($urandom(32'hD088));
    ea = '0;
    eb = '0;
    fa = 1'h0;
    fb = 1'h0;
    e_rd = 16'h0000;
    e_ref = 1'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    // Section loads leave the flag stale; a zero-product accumulate refreshes it.
    v = '0;
    b = '{wr: 1'h1, rd: 1'h0, addr: OFS_A_MID, wdata: 16'h8000};
    step(v, b, 1'h1);
    b.addr = OFS_A_HIGH;
    b.wdata = 16'h0001;
    step(v, b, 1'h1);
    load <= 1'h1;
    b = '{wr: 1'h0, rd: 1'h1, addr: OFS_STATUS, wdata: 16'h0000};
    step(v, b, 1'h1);
    v = '{valid: 1'h1, cond_true: 1'h1, kind: K_MAC_ADD, fmt: both_signed, x_src: SRC_XIN0,
          y_src: SRC_YIN0, default: '0};
    step(v, '0, 1'h1);
    v.kind = K_SAT;
    step(v, '0, 1'h1);
    for (int i = 0; i < 6000; i++) begin
      v = mrcs_op_t'($bits(mrcs_op_t)'($urandom));
      v.kind = mrcs_kind_t'($urandom_range(5));
      v.x_src = mrcs_src_t'($urandom_range(11));
      v.y_src = mrcs_src_t'($urandom_range(12));
      v.valid = ($urandom_range(7) != 0);
      v.cond_true = ($urandom_range(7) != 0);
      v.restricted = ($urandom_range(3) == 0);
      b = mrcs_bus_t'($bits(mrcs_bus_t)'($urandom));
      b.wr = ($urandom_range(5) == 0);
      b.rd = !b.wr && ($urandom_range(1) == 1);
      load_val <= mrcs_opnd_t'($bits(mrcs_opnd_t)'({$urandom, $urandom, $urandom, $urandom}));
      load <= ($urandom_range(1) == 1);
      step(v, b, $urandom_range(15) != 0);
    end
    step('0, '0, 1'h1);
    end_sim();
  end

  // About 6000 cycles of work; four times that is a hang.
  initial begin : watchdog
    #100000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
